// ---- core/ccig_ctl.sv ----
`timescale 1ns/1ps
// controller end: one-cycle strobed transfers from a simple command port
module ccig_ctl
   import ccig_pkg::*;
(
   input  wire logic                core_clk,
   input  wire logic                resetn,
   ccig_if.ctl                      bus,
   input  wire logic                cmd_valid,
   input  wire logic                cmd_write,
   input  wire logic [1:0]          cmd_target,
   input  wire logic [CCIG_DW-1:0]  cmd_data,
   input  wire logic [CCIG_NCH-1:0] cmd_clear,
   output logic                     cmd_ready,
   output logic                     rsp_valid,
   output logic      [CCIG_DW-1:0]  rsp_data,
   output logic                     irq_pending
);
   import ccig_pkg::*;
   typedef enum logic [1:0]
   {
      CCIG_IDLE = 2'b00,
      CCIG_STRB = 2'b01,
      CCIG_WAIT = 2'b10,
      CCIG_DONE = 2'b11
   } ccig_st_e;

   ccig_st_e           st_r;
   logic               wr_r;
   logic [1:0]         tgt_r;
   logic [CCIG_DW-1:0] dat_r;
   logic [CCIG_NCH-1:0] clr_n_r;
   logic               rv_r;
   logic [CCIG_DW-1:0] rd_r;
   logic               irq_r;

   wire strb = (st_r == CCIG_STRB);
   // target 0 personality, 1 channel load, 2 io, 3 status
   assign bus.data_wr               = dat_r;
   assign bus.wr_n                  = !(strb && wr_r);
   assign bus.rd_n                  = !(strb && !wr_r);
   assign bus.personality_select_n  = !(strb && tgt_r == 2'h0);
   assign bus.channel_load_select_n = !(strb && tgt_r == 2'h1);
   assign bus.io_select_n           = !(strb && tgt_r == 2'h2);
   assign bus.status_select_n       = !(strb && tgt_r == 2'h3);
   assign bus.event_clear_n         = clr_n_r;
   assign cmd_ready                 = (st_r == CCIG_IDLE);
   assign rsp_valid                 = rv_r;
   assign rsp_data                  = rd_r;
   assign irq_pending               = irq_r;

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         st_r    <= CCIG_IDLE;
         wr_r    <= 1'b0;
         tgt_r   <= 2'h0;
         dat_r   <= 8'h00;
         clr_n_r <= 4'hF;
         rv_r    <= 1'b0;
         rd_r    <= 8'h00;
         irq_r   <= 1'b0;
      end
      else
      begin
         irq_r   <= !bus.activity_irq_n;
         clr_n_r <= ~cmd_clear;
         rv_r    <= 1'b0;
         case (st_r)
            CCIG_IDLE:
               if (cmd_valid)
               begin
                  wr_r  <= cmd_write;
                  tgt_r <= cmd_target;
                  dat_r <= cmd_data;
                  st_r  <= CCIG_STRB;
               end
            CCIG_STRB: st_r <= CCIG_WAIT;
            CCIG_WAIT:
            begin
               if (!wr_r)
               begin
                  rd_r <= bus.data_rd;
                  rv_r <= 1'b1;
               end
               st_r <= CCIG_DONE;
            end
            CCIG_DONE: st_r <= CCIG_IDLE;
            default:   st_r <= CCIG_IDLE;
         endcase
      end
   end
endmodule : ccig_ctl

// ---- core/ccig_dev.sv ----
`timescale 1ns/1ps
module ccig_dev
   import ccig_pkg::*;
(
   input  wire logic                core_clk,
   input  wire logic                resetn,
   ccig_if.dev                      bus,
   input  wire logic [CCIG_NCH-1:0] voice_detect,
   input  wire logic [CCIG_NCH-1:0] receive_inhibit_n,
   input  wire logic [CCIG_DW-1:0]  isolated_input_cathode,
   input  wire logic [CCIG_NCH*CCIG_DIV_W-1:0] tone_half_period,
   output logic      [CCIG_NCH-1:0] simplex_select,
   output logic      [CCIG_NCH-1:0] termination_disable,
   output logic      [CCIG_NCH-1:0] carrier_input_select_n,
   output logic      [CCIG_NCH-1:0] activity_led,
   output logic      [CCIG_NCH-1:0] filter_clk,
   output logic      [CCIG_DW-1:0]  relay_contact_a
);
   import ccig_pkg::*;

   logic [CCIG_DW-1:0]  pers_r;
   logic [CCIG_DW-1:0]  term_r;
   logic [CCIG_DW-1:0]  gpo_r;
   logic                pers_wr_d_r;
   logic                gpo_wr_d_r;
   logic [CCIG_NCH-1:0] act_d_r;
   logic [CCIG_NCH-1:0] key_event_flag;
   logic [CCIG_NCH-1:0] unkey_event_flag;
   logic [CCIG_NCH-1:0] led_r;
   logic                irq_r;
   logic [CCIG_DW-1:0]  rd_r;
   logic                rd_oe_n_r;

   // a select strobe counts only while its bus strobe is low too
   function automatic logic strobe_hit
   (
      input logic sel_n,
      input logic str_n
   );
      return !sel_n && !str_n;
   endfunction : strobe_hit

   wire pers_wr = strobe_hit(bus.personality_select_n, bus.wr_n);
   wire load_wr = strobe_hit(bus.channel_load_select_n, bus.wr_n);
   wire gpo_wr  = strobe_hit(bus.io_select_n, bus.wr_n);
   wire gpi_rd  = strobe_hit(bus.io_select_n, bus.rd_n);
   wire sta_rd  = strobe_hit(bus.status_select_n, bus.rd_n);
   // edge-loaded latches take the first strobed cycle only
   wire pers_ld = pers_wr && !pers_wr_d_r;
   wire gpo_ld  = gpo_wr && !gpo_wr_d_r;

   wire [CCIG_NCH-1:0] csel_n = pers_r[CCIG_CSEL_LSB +: CCIG_NCH];
   wire [CCIG_NCH-1:0] cd_n   =
      isolated_input_cathode[CCIG_CD_LSB +: CCIG_NCH];
   wire [CCIG_NCH-1:0] act;
   wire [CCIG_NCH-1:0] key_set = act & ~act_d_r;
   wire [CCIG_NCH-1:0] unk_set = ~act & act_d_r;
   wire [CCIG_NCH-1:0] pend    = key_event_flag | unkey_event_flag;

   // per channel: pick the activity source and run a tone divider
   genvar g;
   generate
      for (g = 0; g < CCIG_NCH; g++)
      begin : g_ch
         // carrier detect replaces the voice detector when selected
         assign act[g] = receive_inhibit_n[g] &&
            (!csel_n[g] ? !cd_n[g] : voice_detect[g]);
         ccig_tone_div u_div
         (
            .core_clk    (core_clk),
            .resetn      (resetn),
            .half_period (tone_half_period[g*CCIG_DIV_W +: CCIG_DIV_W]),
            .filter_clk  (filter_clk[g])
         );
      end
   endgenerate

   // lowest pending channel answers the status read
   function automatic logic [CCIG_DW-1:0] stat_byte
   (
      input logic [CCIG_NCH-1:0] p,
      input logic [CCIG_NCH-1:0] k
   );
      logic [CCIG_DW-1:0] b;
      logic               found;
      b     = CCIG_FLAG_IDLE;
      found = 1'b0;
      for (int i = 0; i < CCIG_NCH; i++)
      begin
         if (p[i] && !found)
         begin
            found                    = 1'b1;
            b[CCIG_FLAG_LSB + i]     = 1'b0;
            b[CCIG_STAT_BIT]         = !k[i];
         end
      end
      return b;
   endfunction : stat_byte

   wire [CCIG_DW-1:0] rd_nxt = gpi_rd ? isolated_input_cathode
                                      : stat_byte(pend, key_event_flag);

   assign simplex_select         = pers_r[CCIG_SPLX_LSB +: CCIG_NCH];
   assign carrier_input_select_n = csel_n;
   assign termination_disable    = term_r[CCIG_NCH-1:0];
   assign relay_contact_a        = gpo_r;
   assign activity_led           = led_r;
   assign bus.activity_irq_n     = irq_r;
   assign bus.data_rd            = rd_r;
   assign bus.data_rd_oe_n       = rd_oe_n_r;

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pers_r      <= CCIG_PERS_RST;
         pers_wr_d_r <= 1'b0;
      end
      else
      begin
         pers_wr_d_r <= pers_wr;
         if (pers_ld)
            pers_r <= bus.data_wr;
      end
   end

   // follows the bus for every strobed cycle, holds otherwise
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         term_r <= CCIG_TERM_RST;
      else if (load_wr)
         term_r <= bus.data_wr;
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         gpo_r      <= CCIG_OUT_RST;
         gpo_wr_d_r <= 1'b0;
      end
      else
      begin
         gpo_wr_d_r <= gpo_wr;
         if (gpo_ld)
            gpo_r <= bus.data_wr;
      end
   end

   // hardware set wins over a clear in the same cycle
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         act_d_r          <= '0;
         key_event_flag   <= '0;
         unkey_event_flag <= '0;
         led_r            <= '0;
         irq_r            <= 1'b1;
      end
      else
      begin
         act_d_r          <= act;
         led_r            <= act;
         key_event_flag   <= key_set |
                             (key_event_flag & bus.event_clear_n);
         unkey_event_flag <= unk_set |
                             (unkey_event_flag & bus.event_clear_n);
         irq_r            <= ~|(pend | key_set | unk_set);
      end
   end

   // registered read drive: it answers one cycle after the strobe
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rd_r      <= CCIG_FLAG_IDLE;
         rd_oe_n_r <= 1'b1;
      end
      else
      begin
         rd_r      <= rd_nxt;
         rd_oe_n_r <= !(gpi_rd || sta_rd);
      end
   end
endmodule : ccig_dev

// ---- core/ccig_tone_div.sv ----
`timescale 1ns/1ps
module ccig_tone_div
   import ccig_pkg::*;
(
   input  wire logic                  core_clk,
   input  wire logic                  resetn,
   input  wire logic [CCIG_DIV_W-1:0] half_period,
   output logic                       filter_clk
);
   logic [CCIG_DIV_W-1:0] cnt_r;
   logic                  clk_r;
   // wrap on the last count so each level lasts exactly half_period edges
   wire                   wrap = (cnt_r >= half_period - CCIG_DIV_W'(1));
   assign filter_clk = clk_r;
   // half_period of zero stops the clock rather than toggling every edge
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cnt_r <= '0;
         clk_r <= 1'b0;
      end
      else if (half_period == '0)
      begin
         cnt_r <= '0;
         clk_r <= 1'b0;
      end
      else if (wrap)
      begin
         cnt_r <= '0;
         clk_r <= ~clk_r;
      end
      else
         cnt_r <= cnt_r + 1'b1;
   end
endmodule : ccig_tone_div

// ---- pkg/ccig_if.sv ----
`timescale 1ns/1ps
interface ccig_if;
   import ccig_pkg::*;
   logic [CCIG_DW-1:0] data_wr;
   logic [CCIG_DW-1:0] data_rd;
   logic               data_rd_oe_n;
   logic               wr_n;
   logic               rd_n;
   logic               personality_select_n;
   logic               channel_load_select_n;
   logic               io_select_n;
   logic               status_select_n;
   logic               activity_irq_n;
   logic [CCIG_NCH-1:0] event_clear_n;
   modport dev
   (
      input  data_wr,
      output data_rd,
      output data_rd_oe_n,
      input  wr_n,
      input  rd_n,
      input  personality_select_n,
      input  channel_load_select_n,
      input  io_select_n,
      input  status_select_n,
      output activity_irq_n,
      input  event_clear_n
   );
   modport ctl
   (
      output data_wr,
      input  data_rd,
      input  data_rd_oe_n,
      output wr_n,
      output rd_n,
      output personality_select_n,
      output channel_load_select_n,
      output io_select_n,
      output status_select_n,
      input  activity_irq_n,
      output event_clear_n
   );
endinterface : ccig_if

// ---- pkg/ccig_pkg.sv ----
package ccig_pkg;
   localparam int    CCIG_NCH        = 4;
   localparam int    CCIG_DW         = 8;
   // tone filter clock runs at this multiple of the tone frequency
   localparam int    CCIG_TONE_MULT  = 100;
   localparam int    CCIG_HALF_MULT  = CCIG_TONE_MULT / 2;
   localparam int    CCIG_DIV_W      = 24;
   localparam int    CCIG_CNT_W      = 7;
   // personality byte layout: simplex in low nibble, carrier select high
   localparam int    CCIG_SPLX_LSB   = 0;
   localparam int    CCIG_CSEL_LSB   = 4;
   // channel flags on data bits 4..7, key status on bit 0
   localparam int    CCIG_FLAG_LSB   = 4;
   localparam int    CCIG_STAT_BIT   = 0;
   // isolated inputs 5..8 double as carrier detect for channels 1..4
   localparam int    CCIG_CD_LSB     = 4;
   localparam logic [7:0] CCIG_PERS_RST = 8'hF0;
   localparam logic [7:0] CCIG_TERM_RST = 8'h00;
   localparam logic [7:0] CCIG_OUT_RST  = 8'h00;
   localparam logic [7:0] CCIG_FLAG_IDLE = 8'hFF;
   localparam logic [CCIG_CNT_W-1:0] CCIG_CNT_ZERO = 7'h00;
endpackage : ccig_pkg

// ---- sim/ccig_asserts.sv ----
`timescale 1ns/1ps
module ccig_asserts
(
   input wire logic       core_clk,
   input wire logic       resetn,
   input wire logic [7:0] data_wr,
   input wire logic [7:0] data_rd,
   input wire logic       data_rd_oe_n,
   input wire logic       wr_n,
   input wire logic       rd_n,
   input wire logic       personality_select_n,
   input wire logic       channel_load_select_n,
   input wire logic       io_select_n,
   input wire logic       status_select_n,
   input wire logic       activity_irq_n,
   input wire logic [3:0] event_clear_n
);
   default clocking dcb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);
   sequence s_io_rd;
      !rd_n && !io_select_n;
   endsequence
   sequence s_oe_pulse;
      !data_rd_oe_n ##1 data_rd_oe_n;
   endsequence
   // only trust the flags when no clear can race the read
   sequence s_stat_rd;
      !rd_n && !status_select_n && !activity_irq_n &&
      (&event_clear_n) && $past(&event_clear_n);
   endsequence
   AST_WR_PULSE: assert property ($fell(wr_n) |=> wr_n)
      else $error("write strobe longer than one cycle");
   AST_RD_PULSE: assert property ($fell(rd_n) |=> rd_n)
      else $error("read strobe longer than one cycle");
   AST_SEL_ONEHOT: assert property
      ($onehot0({~personality_select_n, ~channel_load_select_n,
      ~io_select_n, ~status_select_n}))
      else $error("two selects low together");
   AST_WR_RD_EXCL: assert property (!(!wr_n && !rd_n))
      else $error("read and write strobes low together");
   AST_IO_READ: assert property (s_io_rd |=> s_oe_pulse)
      else $error("read drive not one cycle after io read");
   AST_OE_CAUSE: assert property
      ($fell(data_rd_oe_n) |-> $past(rd_n) == 1'b0)
      else $error("bus driven without a read strobe");
   AST_STAT_FLAG: assert property
      (s_stat_rd |=> data_rd[7:4] != 4'hF)
      else $error("pending interrupt shows no channel flag");
   AST_SPACING: assert property
      ((!wr_n || !rd_n) |=> (wr_n && rd_n)[*3])
      else $error("strobes closer than four cycles");
endmodule : ccig_asserts

// ---- sim/channel_control_io_glue_bench.sv ----
`timescale 1ns/1ps
module channel_control_io_glue_bench;
   import ccig_pkg::*;
   logic        core_clk;
   logic        resetn;
   logic        cmd_valid;
   logic        cmd_write;
   logic [1:0]  cmd_target;
   logic [7:0]  cmd_data;
   logic [3:0]  cmd_clear;
   logic        cmd_ready;
   logic        rsp_valid;
   logic [7:0]  rsp_data;
   logic        irq_pending;
   logic [3:0]  voice_detect;
   logic [3:0]  receive_inhibit_n;
   logic [7:0]  iso_in;
   logic [3:0]  splx;
   logic [3:0]  term;
   logic [3:0]  csel_n;
   logic [3:0]  led;
   logic [3:0]  fclk;
   logic [7:0]  relay;
   logic [7:0]  rd;
   int          fail_count;
   int          n_tests;
   int          k;
   ccig_if bus_if();
   ccig_dev ccig_dev_inst (.core_clk(core_clk), .resetn(resetn),
      .bus(bus_if.dev),
      .voice_detect(voice_detect), .receive_inhibit_n(receive_inhibit_n),
      .isolated_input_cathode(iso_in), .tone_half_period({4{24'h000005}}),
      .simplex_select(splx), .termination_disable(term),
      .carrier_input_select_n(csel_n), .activity_led(led),
      .filter_clk(fclk), .relay_contact_a(relay));
   ccig_ctl ccig_ctl_inst (.core_clk(core_clk), .resetn(resetn),
      .bus(bus_if.ctl),
      .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_target(cmd_target),
      .cmd_data(cmd_data), .cmd_clear(cmd_clear), .cmd_ready(cmd_ready),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .irq_pending(irq_pending));
   ccig_asserts ccig_asserts_inst (.core_clk(core_clk), .resetn(resetn),
      .data_wr(bus_if.data_wr), .data_rd(bus_if.data_rd),
      .data_rd_oe_n(bus_if.data_rd_oe_n), .wr_n(bus_if.wr_n),
      .rd_n(bus_if.rd_n),
      .personality_select_n(bus_if.personality_select_n),
      .channel_load_select_n(bus_if.channel_load_select_n),
      .io_select_n(bus_if.io_select_n),
      .status_select_n(bus_if.status_select_n),
      .activity_irq_n(bus_if.activity_irq_n),
      .event_clear_n(bus_if.event_clear_n));
   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   task print_verdict;
      $display("checks=%0d errors=%0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : print_verdict
   task chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         fail_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // one transfer; a stuck handshake ends the run
   task xfer(input logic wr, input logic [1:0] tgt, input logic [7:0] d);
      k = 0;
      while (cmd_ready !== 1'b1 && k < 20)
      begin
         @(negedge core_clk);
         k++;
      end
      if (k == 20)
      begin
         fail_count++;
         print_verdict();
      end
      cmd_valid = 1'b1;
      cmd_write = wr;
      cmd_target = tgt;
      cmd_data = d;
      @(negedge core_clk);
      cmd_valid = 1'b0;
      for (k = 0; k < 20 && cmd_ready !== 1'b1; k++)
      begin
         if (rsp_valid === 1'b1)
            rd = rsp_data;
         @(negedge core_clk);
      end
      if (k == 20)
      begin
         fail_count++;
         print_verdict();
      end
   endtask : xfer
   // after a key or unkey event: read status, check flag nibble and status bit, then clear
   task event_seq(input logic [3:0] flags, input logic keyed);
      repeat (4) @(negedge core_clk);
      chk({7'h00, bus_if.activity_irq_n}, 8'h00);
      chk({7'h00, irq_pending}, 8'h01);
      xfer(1'b0, 2'h3, 8'h00);
      chk({rd[7:4], 3'h0, rd[0]}, {flags, 3'h0, keyed});
      cmd_clear = ~flags;
      repeat (4) @(negedge core_clk);
      cmd_clear = 4'h0;
      repeat (2) @(negedge core_clk);
      chk({7'h00, bus_if.activity_irq_n}, 8'h01);
   endtask : event_seq
   initial
   begin
      fail_count = 0;
      n_tests = 0;
      resetn = 1'b0;
      {cmd_valid, cmd_write, cmd_target, cmd_data, cmd_clear} = '0;
      voice_detect = 4'h0;
      receive_inhibit_n = 4'hF;
      iso_in = 8'hFF;
      rd = 8'h00;
      repeat (8) @(negedge core_clk);
      chk({splx, term}, 8'h00);
      chk({csel_n, 3'h0, bus_if.activity_irq_n}, 8'hF1);
      chk(relay, CCIG_OUT_RST);
      resetn = 1'b1;
      @(negedge core_clk);
      xfer(1'b1, 2'h0, 8'h5A);
      chk({csel_n, splx}, 8'h5A);
      xfer(1'b1, 2'h1, 8'h09);
      chk({4'h0, term}, 8'h09);
      xfer(1'b1, 2'h2, 8'hC3);
      chk(relay, 8'hC3);
      xfer(1'b1, 2'h2, 8'h3C);
      chk(relay, 8'h3C);
      iso_in = 8'hA5;
      xfer(1'b0, 2'h2, 8'h00);
      chk(rd, 8'hA5);
      iso_in = 8'hFF;
      xfer(1'b1, 2'h0, 8'hF0);
      voice_detect = 4'h2;
      event_seq(4'hD, 1'b0);
      voice_detect = 4'h0;
      event_seq(4'hD, 1'b1);
      receive_inhibit_n = 4'hB;
      voice_detect = 4'h4;
      repeat (6) @(negedge core_clk);
      chk({3'h0, bus_if.activity_irq_n, led}, 8'h10);
      voice_detect = 4'h0;
      repeat (3) @(negedge core_clk);
      receive_inhibit_n = 4'hF;
      xfer(1'b1, 2'h0, 8'h70);
      chk({csel_n, splx}, 8'h70);
      iso_in = 8'h7F;
      event_seq(4'h7, 1'b0);
      chk({4'h0, led}, 8'h08);
      // start from a low phase so the whole high phase is counted
      k = 0;
      while (fclk[0] === 1'b1 && k < 40)
      begin
         @(negedge core_clk);
         k++;
      end
      k = 0;
      while (fclk[0] !== 1'b1 && k < 40)
      begin
         @(negedge core_clk);
         k++;
      end
      for (k = 0; k < 40 && fclk[0] === 1'b1; k++)
         @(negedge core_clk);
      chk(8'(k), 8'h05);
      print_verdict();
   end
endmodule : channel_control_io_glue_bench
